// ---- rtl/shps_defs.svh ----
// constants for the sd present-state register bank
`ifndef SHPS_DEFS_SVH
`define SHPS_DEFS_SVH
`define SHPS_ADDR_CH0       32'h4ac0_0024
`define SHPS_ADDR_CH1       32'h4a80_0024
`define SHPS_RESET_VALUE    32'h000a_0000
`define SHPS_BIT_CMD        24
`define SHPS_BIT_DAT_HI     23
`define SHPS_BIT_DAT_LO     20
`define SHPS_BIT_WP         19
`define SHPS_BIT_CD_RAW     18
`define SHPS_BIT_STABLE     17
`define SHPS_BIT_INSERTED   16
`define SHPS_RSV_HI         31
`define SHPS_RSV_LO         25
`define SHPS_WP_TIED        1'h1
`define SHPS_CD_TIED        1'h0
`define SHPS_CLK_PERIOD_NS  50
`define SHPS_DEBOUNCE_NS    100000
`define SHPS_DEBOUNCE_CYC   ((`SHPS_DEBOUNCE_NS + `SHPS_CLK_PERIOD_NS - 1) / `SHPS_CLK_PERIOD_NS)
`define SHPS_RESP_OKAY      2'h0
`define SHPS_RESP_SLVERR    2'h2
`endif

// ---- rtl/shps_pkg.sv ----
// types shared by the sd present-state register bank
package shps_pkg;
  typedef struct packed {
    logic       cmd;
    logic [3:0] dat;
  } shps_sd_lines_type;

  typedef enum logic {
    SHPS_IDLE = 1'b0,
    SHPS_RESP = 1'b1
  } shps_bus_state_type;
endpackage : shps_pkg

// ---- rtl/shps_present_state.sv ----
// sd host present-state status registers, one or two channels, axi4-lite slave
`timescale 1ns/10ps
`include "shps_defs.svh"

module shps_present_state #(
  parameter int CHANNELS        = 2,
  parameter int DEBOUNCE_CYCLES = `SHPS_DEBOUNCE_CYC
) (
  // clock and reset
  input  wire  logic                                          aclk,
  input  wire  logic                                          aresetn,
  // axi4-lite write address and data
  input  wire  logic                                          s_axi_awvalid,
  output logic                                                s_axi_awready,
  input  wire  logic [31:0]                                   s_axi_awaddr,
  input  wire  logic [2:0]                                    s_axi_awprot,
  input  wire  logic                                          s_axi_wvalid,
  output logic                                                s_axi_wready,
  input  wire  logic [31:0]                                   s_axi_wdata,
  input  wire  logic [3:0]                                    s_axi_wstrb,
  // axi4-lite write response
  output logic                                                s_axi_bvalid,
  input  wire  logic                                          s_axi_bready,
  output logic [1:0]                                          s_axi_bresp,
  // axi4-lite read
  input  wire  logic                                          s_axi_arvalid,
  output logic                                                s_axi_arready,
  input  wire  logic [31:0]                                   s_axi_araddr,
  input  wire  logic [2:0]                                    s_axi_arprot,
  output logic                                                s_axi_rvalid,
  input  wire  logic                                          s_axi_rready,
  output logic [31:0]                                         s_axi_rdata,
  output logic [1:0]                                          s_axi_rresp,
  // sd pins, asynchronous
  input  wire  shps_pkg::shps_sd_lines_type [CHANNELS-1:0]    sd_lines,
  // controller side, same clock
  input  wire  logic [CHANNELS-1:0]                           soft_reset_all,
  output logic [CHANNELS-1:0]                                 card_inserted_debounced
);

  localparam int CNT_W = $clog2(DEBOUNCE_CYCLES + 1);

  // only two channel addresses exist, and a single count would hide the unsettled phase
  if (CHANNELS < 1 || CHANNELS > 2) begin : g_bad_channels
    $error("shps: only one or two channels have an address");
  end
  if (DEBOUNCE_CYCLES < 2) begin : g_bad_debounce
    $error("shps: debounce count must be at least two");
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [31:0] status [CHANNELS];

  function automatic logic [31:0] chan_addr(input int idx);
    chan_addr = (idx == 0) ? `SHPS_ADDR_CH0 : `SHPS_ADDR_CH1;
  endfunction : chan_addr

  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : g_ch
      shps_pkg::shps_sd_lines_type lines_meta_q;
      shps_pkg::shps_sd_lines_type lines_q;
      logic                        wp_meta_q;
      logic                        wp_q;
      logic                        cd_n_meta_q;
      logic                        cd_n_q;
      logic                        cd_raw;
      logic                        cd_prev_q;
      logic [CNT_W-1:0]            cnt_q;
      logic                        stable_q;
      logic                        inserted_q;

      // line levels: two flops, soft reset returns them to reset view
      always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset_all[c]) begin
          lines_meta_q <= '0;
          lines_q      <= '0;
        end else begin
          lines_meta_q <= sd_lines[c];
          lines_q      <= lines_meta_q;
        end
      end

      // pins tied inside the device; kept through the synchroniser so a real pin drops in
      always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset_all[c]) begin
          wp_meta_q <= 1'h1;
          wp_q      <= 1'h1;
        end else begin
          wp_meta_q <= `SHPS_WP_TIED;
          wp_q      <= wp_meta_q;
        end
      end

      // card detect on hardware reset only: a soft reset here would fake a removal
      // and drag the stable and inserted bits down through the debouncer
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cd_n_meta_q <= 1'h1;
          cd_n_q      <= 1'h1;
        end else begin
          cd_n_meta_q <= `SHPS_CD_TIED;
          cd_n_q      <= cd_n_meta_q;
        end
      end

      assign cd_raw = ~cd_n_q;

      // debouncer runs on hardware reset only, soft reset must not touch it
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cd_prev_q  <= 1'h0;
          cnt_q      <= '0;
          stable_q   <= 1'h1;
          inserted_q <= 1'h0;
        end else if (cd_raw != cd_prev_q) begin
          cd_prev_q  <= cd_raw;
          cnt_q      <= '0;
          stable_q   <= 1'h0;
          inserted_q <= 1'h0;
        end else if (cnt_q != CNT_W'(DEBOUNCE_CYCLES)) begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q == CNT_W'(DEBOUNCE_CYCLES - 1)) begin
            stable_q   <= 1'h1;
            inserted_q <= cd_raw;
          end
        end
      end

      assign card_inserted_debounced[c] = inserted_q;

      always_comb begin
        status[c]                                      = '0;
        status[c][`SHPS_BIT_CMD]                       = lines_q.cmd;
        status[c][`SHPS_BIT_DAT_HI:`SHPS_BIT_DAT_LO]   = lines_q.dat;
        status[c][`SHPS_BIT_WP]                        = wp_q;
        status[c][`SHPS_BIT_CD_RAW]                    = cd_raw;
        status[c][`SHPS_BIT_STABLE]                    = stable_q;
        status[c][`SHPS_BIT_INSERTED]                  = inserted_q;
      end

      // quiet window covers both synchroniser flops and the sampling edge
      sequence s_quiet3;
        (aresetn && !soft_reset_all[c]) [*3];
      endsequence

      sequence s_released;
        $past(aresetn) == 1'b0;
      endsequence

      // last count of an unchanged level; the next edge must settle both flags
      sequence s_count_done;
        !stable_q && cd_raw == cd_prev_q && cnt_q == CNT_W'(DEBOUNCE_CYCLES - 1);
      endsequence

      a_cmd_line_live: assert property (s_quiet3 |-> lines_q.cmd == $past(sd_lines[c].cmd, 2))
        else $error("cmd level bit does not follow the pin");
      a_dat_line_order: assert property (s_quiet3 |-> status[c][`SHPS_BIT_DAT_HI] == $past(sd_lines[c].dat[3], 2)
        && status[c][`SHPS_BIT_DAT_LO] == $past(sd_lines[c].dat[0], 2))
        else $error("data line bits out of order");
      a_wp_always_set: assert property (status[c][`SHPS_BIT_WP] == 1'b1)
        else $error("write protect bit not showing write enabled");
      a_cd_raw_present: assert property (s_quiet3 |-> status[c][`SHPS_BIT_CD_RAW] == 1'b1)
        else $error("raw card detect not showing card present");
      a_stable_drops: assert property ($changed(cd_raw) |=> !stable_q ##1 !stable_q)
        else $error("stable bit did not drop on a level change");
      a_stable_soft_rst: assert property (soft_reset_all[c] && stable_q && $stable(cd_raw) |=> stable_q)
        else $error("soft reset disturbed the stable bit");
      a_reset_value_ch: assert property (s_released |-> status[c] == `SHPS_RESET_VALUE)
        else $error("status not at reset value after reset");
      a_inserted_stable: assert property (inserted_q |-> stable_q
        && (!$rose(inserted_q) || $past(cd_raw)))
        else $error("card inserted without a settled card detect");
      a_stable_settles: assert property (s_count_done |=> stable_q && inserted_q == $past(cd_raw))
        else $error("stable bit did not settle after the count");
      a_lines_soft_clear: assert property (soft_reset_all[c] |=> lines_q == '0)
        else $error("soft reset left the line snapshot standing");
    end
  endgenerate

  // write side: address and data taken in either order, then one response
  logic        aw_held_q;
  logic        w_held_q;
  logic        aw_hit_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        aw_hit;

  always_comb begin
    aw_hit = 1'b0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (s_axi_awaddr == chan_addr(i)) aw_hit = 1'b1;
    end
  end

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_hit_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `SHPS_RESP_OKAY;
    end else if (bvalid_q) begin
      if (s_axi_bready) bvalid_q <= 1'b0;
    end else if ((aw_held_q || s_axi_awvalid) && (w_held_q || s_axi_wvalid)) begin
      // read-only bank: write data is dropped, mapped address still answers okay
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      bvalid_q  <= 1'b1;
      bresp_q   <= (aw_held_q ? aw_hit_q : aw_hit) ? `SHPS_RESP_OKAY : `SHPS_RESP_SLVERR;
    end else begin
      if (s_axi_awvalid) begin
        aw_held_q <= 1'b1;
        aw_hit_q  <= aw_hit;
      end
      if (s_axi_wvalid) w_held_q <= 1'b1;
    end
  end

  // read side: one cycle from address to data
  shps_pkg::shps_bus_state_type rd_state_q;
  logic [31:0]                  rdata_q;
  logic [1:0]                   rresp_q;
  logic [31:0]                  rd_word;
  logic                         rd_hit;

  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (s_axi_araddr == chan_addr(i)) begin
        rd_word = status[i];
        rd_hit  = 1'b1;
      end
    end
  end

  assign s_axi_arready = (rd_state_q == shps_pkg::SHPS_IDLE);
  assign s_axi_rvalid  = (rd_state_q == shps_pkg::SHPS_RESP);
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= shps_pkg::SHPS_IDLE;
      rdata_q    <= '0;
      rresp_q    <= `SHPS_RESP_OKAY;
    end else begin
      case (rd_state_q)
        shps_pkg::SHPS_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_q <= shps_pkg::SHPS_RESP;
            rdata_q    <= rd_word;
            rresp_q    <= rd_hit ? `SHPS_RESP_OKAY : `SHPS_RESP_SLVERR;
          end
        end
        shps_pkg::SHPS_RESP: begin
          if (s_axi_rready) rd_state_q <= shps_pkg::SHPS_IDLE;
        end
        default: rd_state_q <= shps_pkg::SHPS_IDLE;
      endcase
    end
  end

  a_reserved_reads_zero: assert property (s_axi_rvalid |-> s_axi_rdata[`SHPS_RSV_HI:`SHPS_RSV_LO] == '0)
    else $error("reserved bits read nonzero");

  // read answer carries the word seen at the taking edge
  a_rd_answer_next: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rdata == $past(rd_word))
    else $error("read answer missing or not the addressed word");
  a_wr_answer_next: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid)
    else $error("write answer missing after address and data");
  a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == `SHPS_RESP_SLVERR
    |-> s_axi_rdata == '0)
    else $error("unmapped read returned data");

endmodule : shps_present_state

// ---- sim/shps_card_model.sv ----
// card-side pin model: drives cmd and dat or leaves them to the pull-ups
`timescale 1ns/10ps
module shps_card_model (
  // pin control from the bench
  input  wire logic                   drive_en,
  input  wire logic [4:0]             level,
  // card pins, cmd in the top bit
  output shps_pkg::shps_sd_lines_type lines
);
  // released lines sit at the pull-up level, never at the last driven value
  assign lines = drive_en ? shps_pkg::shps_sd_lines_type'(level) : shps_pkg::shps_sd_lines_type'(5'h1f);
endmodule : shps_card_model

// ---- sim/shps_present_state_test.sv ----
// self-checking bench for the present-state register bank
`timescale 1ns/10ps
`include "shps_defs.svh"
module shps_present_state_test;
  logic                              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic                              awready, wready, bvalid, arready, rvalid;
  logic [31:0]                       awaddr, wdata, araddr, rdata, d;
  logic [1:0]                        bresp, rresp, r, soft_rst, cid, drv;
  logic [4:0]                        lvl [2];
  wire shps_pkg::shps_sd_lines_type [1:0] sd_lines;
  int                                bad_count, total_checks, cycles;

  shps_card_model card0 (.drive_en(drv[0]), .level(lvl[0]), .lines(sd_lines[0]));
  shps_card_model card1 (.drive_en(drv[1]), .level(lvl[1]), .lines(sd_lines[1]));
  shps_present_state #(.CHANNELS(2), .DEBOUNCE_CYCLES(4)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .sd_lines(sd_lines), .soft_reset_all(soft_rst), .card_inserted_debounced(cid));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ready is looked at mid-cycle, where it already shows what the next edge samples
  task automatic rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
  endtask : rd

  task automatic wr(input logic [31:0] a);
    logic aw_ok, w_ok, aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= 32'hffff_ffff;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      aw_ok = !aw_done && awready === 1'b1;
      w_ok = !w_done && wready === 1'b1;
      @(posedge aclk);
      if (aw_ok) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_ok) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end while (!(aw_done && w_done));
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
  endtask : wr

  task automatic pins(input logic [1:0] en, input logic [4:0] l0, input logic [4:0] l1);
    drv <= en;
    lvl[0] <= l0;
    lvl[1] <= l1;
    repeat (3) @(posedge aclk);
  endtask : pins

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, arvalid} = 4'h0;
    {bready, rready} = 2'h3;
    {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
    {soft_rst, drv} = 4'h0;
    lvl[0] = 5'h00;
    lvl[1] = 5'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SHPS_ADDR_CH0); check("reset ch0", d, `SHPS_RESET_VALUE);
    @(posedge aclk);
    rd(`SHPS_ADDR_CH1); check("settling ch1", d, 32'h01fc_0000);
    repeat (12) @(posedge aclk);
    check("inserted", {30'h0, cid}, 32'h3);
    rd(`SHPS_ADDR_CH1); check("idle ch1", d, 32'h01ff_0000);
    for (int i = 0; i < 5; i++) begin
      pins(2'h3, 5'h01 << i, ~(5'h01 << i));
      rd(`SHPS_ADDR_CH0); check("lines ch0", d, {7'h00, 5'h01 << i, 4'hf, 16'h0000});
      rd(`SHPS_ADDR_CH1); check("lines ch1", d, {7'h00, ~(5'h01 << i), 4'hf, 16'h0000});
    end
    soft_rst <= 2'h1;
    repeat (3) @(posedge aclk);
    rd(`SHPS_ADDR_CH0); check("soft reset ch0", d, 32'h000f_0000);
    rd(`SHPS_ADDR_CH1); check("soft reset ch1", d, 32'h00ff_0000);
    soft_rst <= 2'h0;
    repeat (12) @(posedge aclk);
    check("inserted after soft", {30'h0, cid}, 32'h3);
    wr(`SHPS_ADDR_CH0); check("write resp", {30'h0, r}, {30'h0, `SHPS_RESP_OKAY});
    rd(`SHPS_ADDR_CH0); check("after write", d, 32'h010f_0000);
    wr(32'h4ac0_0028); check("unmapped write", {30'h0, r}, {30'h0, `SHPS_RESP_SLVERR});
    rd(32'h4ac0_0028); check("unmapped data", d, 32'h0);
    check("unmapped read", {30'h0, r}, {30'h0, `SHPS_RESP_SLVERR});
    pins(2'h0, 5'h00, 5'h00);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SHPS_ADDR_CH1); check("reset ch1", d, `SHPS_RESET_VALUE);
    complete_run();
  end
endmodule : shps_present_state_test
